// File: hw/regbuf_cfg.svh
`ifndef REGBUF_CFG_SVH
`define REGBUF_CFG_SVH

// ----------------------------------------------------------------------------
// channel layout
// ----------------------------------------------------------------------------
`define CHANNELS       26
`define WORD_RESET     26'h0000000

// ----------------------------------------------------------------------------
// buffering and pin sampling
// ----------------------------------------------------------------------------
`define FIFO_DEPTH     16
`define SYNC_STAGES    3

`endif

// File: hw/regbuf_pkg.sv
package regbuf_pkg;
`include "regbuf_cfg.svh"

   typedef logic [`CHANNELS-1:0]    word_t;
   typedef logic [`SYNC_STAGES-1:0] sync_t;

endpackage

// File: hw/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = `CHANNELS,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   // pop moves a stored word into the output register
   assign in_ready = (count != CW'(DEPTH));
   assign push     = in_valid & in_ready;
   assign pop      = (count != '0) & (~out_valid | out_ready);

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst | flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst | flush)
      begin
         count <= '0;
      end
      else if (push & ~pop)
      begin
         count <= count + 1'b1;
      end
      else if (pop & ~push)
      begin
         count <= count - 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst | flush)
      begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else if (pop)
      begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end
      else if (out_ready)
      begin
         out_valid <= 1'b0;
      end
   end

   fifo_no_overfill_a : assert property (@(posedge clk) disable iff (rst)
      (count == CW'(DEPTH)) |-> !in_ready)
      else $error("fifo accepts words while full");

endmodule

`default_nettype wire

// File: hw/registered_buffer_26bit.sv
// Contract
// - 26 channels: input, flip-flop, output each
// - capture data at rising clock crossing
// - reset pin low clears flops, outputs low
// - reset pin low disables input receivers
// - standby ignores floating inputs, outputs low
`timescale 1ns/1ps
`default_nettype none

module registered_buffer_26bit (
   input  wire logic             CORE_CLK,
   input  wire logic             RESET,
   input  wire logic             RESET_N_PIN,
   input  wire logic             CLK_T,
   input  wire logic             CLK_C,
   input  wire regbuf_pkg::word_t D,
   input  wire logic             HOLD_OUTPUT,
   output regbuf_pkg::word_t     Q,
   output logic                  RX_ENABLE,
   output logic                  CAPTURE_READY
);
   import regbuf_pkg::*;

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   function automatic logic agree(input logic late2, input logic late3);
      agree = (late2 == late3);
   endfunction

   sync_t rst_sync;
   sync_t ct_sync;
   sync_t cc_sync;
   word_t d_s1;
   word_t d_s2;
   word_t d_s3;
   word_t d_f;
   logic  rst_pin_ok;
   logic  standby;
   logic  ct_f;
   logic  cc_f;
   logic  cross_hi;
   logic  rise;
   logic  fifo_in_ready;
   logic  fifo_out_valid;
   word_t fifo_dout;
   logic  q_load;

   // -------------------------------------------------------------------------
   // reset pin sampling and standby
   // -------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         rst_sync <= '0;
      end
      else
      begin
         rst_sync <= {rst_sync[1:0], RESET_N_PIN};
      end
   end

   // a pin change counts only when the last two stages agree
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         rst_pin_ok <= 1'b0;
      end
      else if (agree(rst_sync[1], rst_sync[2]))
      begin
         rst_pin_ok <= rst_sync[2];
      end
   end

   assign standby = ~rst_pin_ok;

   // receivers stay off while in standby
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         RX_ENABLE <= 1'b0;
      end
      else
      begin
         RX_ENABLE <= ~standby;
      end
   end

   // -------------------------------------------------------------------------
   // clock pair sampling
   // -------------------------------------------------------------------------
   // gating ahead of the first stage keeps floating pins out of the logic
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         ct_sync <= '0;
         cc_sync <= '0;
      end
      else
      begin
         ct_sync <= {ct_sync[1:0], CLK_T & RX_ENABLE};
         cc_sync <= {cc_sync[1:0], CLK_C & RX_ENABLE};
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET | standby)
      begin
         ct_f <= 1'b0;
         cc_f <= 1'b0;
      end
      else
      begin
         if (agree(ct_sync[1], ct_sync[2]))
         begin
            ct_f <= ct_sync[2];
         end
         if (agree(cc_sync[1], cc_sync[2]))
         begin
            cc_f <= cc_sync[2];
         end
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET | standby)
      begin
         cross_hi <= 1'b0;
      end
      else
      begin
         cross_hi <= ct_f & ~cc_f;
      end
   end

   // true phase up and complement down, first cycle only
   assign rise = ct_f & ~cc_f & ~cross_hi;

   // -------------------------------------------------------------------------
   // data channels
   // -------------------------------------------------------------------------
   generate
      for (genvar i = 0; i < `CHANNELS; i++)
      begin : g_chan
         always_ff @(posedge CORE_CLK)
         begin
            if (RESET)
            begin
               d_s1[i] <= 1'b0;
               d_s2[i] <= 1'b0;
               d_s3[i] <= 1'b0;
            end
            else
            begin
               d_s1[i] <= D[i] & RX_ENABLE;
               d_s2[i] <= d_s1[i];
               d_s3[i] <= d_s2[i];
            end
         end

         always_ff @(posedge CORE_CLK)
         begin
            if (RESET | standby)
            begin
               d_f[i] <= 1'b0;
            end
            else if (agree(d_s2[i], d_s3[i]))
            begin
               d_f[i] <= d_s3[i];
            end
         end

         chan_follow_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
            (!standby && d_s2[i] == d_s3[i]) |=> (d_f[i] == $past(d_s3[i])))
            else $error("channel filter lost an agreed input level");
      end
   endgenerate

   // -------------------------------------------------------------------------
   // capture buffer
   // -------------------------------------------------------------------------
   // captures arriving while full are dropped; CAPTURE_READY low warns
   word_fifo #(
      .WIDTH (`CHANNELS),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk       (CORE_CLK),
      .rst       (RESET),
      .flush     (standby),
      .in_valid  (rise),
      .in_ready  (fifo_in_ready),
      .in_data   (d_f),
      .out_valid (fifo_out_valid),
      .out_ready (~HOLD_OUTPUT),
      .out_data  (fifo_dout)
   );

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         CAPTURE_READY <= 1'b0;
      end
      else
      begin
         CAPTURE_READY <= fifo_in_ready & ~standby;
      end
   end

   // -------------------------------------------------------------------------
   // output register
   // -------------------------------------------------------------------------
   assign q_load = fifo_out_valid & ~HOLD_OUTPUT;

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET | standby)
      begin
         Q <= `WORD_RESET;
      end
      else if (q_load)
      begin
         Q <= fifo_dout;
      end
   end

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   standby_q_low_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      standby |=> (Q == `WORD_RESET))
      else $error("outputs not low in standby");

   standby_float_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      standby [*4] |-> (Q == `WORD_RESET && !rise && d_f == `WORD_RESET))
      else $error("floating inputs reached the logic in standby");

   rx_off_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      standby |=> !RX_ENABLE)
      else $error("receivers enabled in standby");

   rx_gate_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      !RX_ENABLE |=> (ct_sync[0] == 1'b0 && cc_sync[0] == 1'b0 && d_s1 == `WORD_RESET))
      else $error("disabled receivers passed a pin level");

   capture_load_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      (q_load && !standby) |=> (Q == $past(fifo_dout)))
      else $error("output missed a buffered capture");

   single_rise_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      rise |=> !rise)
      else $error("one clock crossing captured twice");

   hold_keep_a : assert property (@(posedge CORE_CLK) disable iff (RESET)
      (!standby && !q_load) |=> (Q == $past(Q)))
      else $error("output changed without a capture");

endmodule

`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
   input  wire logic        clk,
   output logic             rst_n_pin,
   output logic             clk_t,
   output logic             clk_c,
   output regbuf_pkg::word_t d
);
   import regbuf_pkg::*;

   logic standby;

   // pin held at a firm low from power-up until wake
   initial
   begin
      rst_n_pin = 1'b0;
      standby   = 1'b1;
      clk_t     = 1'b0;
      clk_c     = 1'b1;
      d         = '0;
   end

   // floating inputs in standby: clock pair toggles every cycle, data bits change at random
   always @(negedge clk)
   begin
      if (standby)
      begin
         d     <= ~d ^ word_t'($urandom);
         clk_t <= ~clk_t;
         clk_c <= clk_t;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wake();
      tick(1);
      standby   = 1'b0;
      clk_t     = 1'b0;
      clk_c     = 1'b1;
      d         = '0;
      rst_n_pin = 1'b1;
   endtask

   task automatic sleep();
      tick(1);
      rst_n_pin = 1'b0;
      standby   = 1'b1;
   endtask

   task automatic set_data(input word_t w);
      tick(1);
      d = w;
   endtask

   // data steady around the rising crossing, pair always opposite
   task automatic send(input word_t w);
      set_data(w);
      tick(4);
      clk_t = 1'b1;
      clk_c = 1'b0;
      tick(4);
      clk_t = 1'b0;
      clk_c = 1'b1;
      tick(3);
   endtask
endmodule

`default_nettype wire

// File: tb/registered_buffer_26bit_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module registered_buffer_26bit_tb;
   import regbuf_pkg::*;

   logic  core_clk, reset, hold_output, mon_on, rx_enable, capture_ready;
   wire   rst_n_pin, clk_t, clk_c;
   word_t d, q, prev_q, w;
   word_t exp_q[$];
   int    error_cnt, cmp_count, i, n;

   host_model u_host (.clk(core_clk), .rst_n_pin(rst_n_pin), .clk_t(clk_t),
                      .clk_c(clk_c), .d(d));

   registered_buffer_26bit u_dut (.CORE_CLK(core_clk), .RESET(reset),
      .RESET_N_PIN(rst_n_pin), .CLK_T(clk_t), .CLK_C(clk_c), .D(d),
      .HOLD_OUTPUT(hold_output), .Q(q), .RX_ENABLE(rx_enable),
      .CAPTURE_READY(capture_ready));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // --------------------------------------------------------------
   // every change of q must be the next modelled word
   // --------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (mon_on && q !== prev_q)
      begin
         w = (exp_q.size() > 0) ? exp_q.pop_front() : prev_q;
         `CHK("q_word", w, q)
      end
      prev_q <= q;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic push_send(input word_t x);
      exp_q.push_back(x);
      u_host.send(x);
   endtask

   task automatic drain();
      for (i = 0; i < 300 && exp_q.size() > 0; i++) tick(1);
      `CHK("drained", 0, exp_q.size());
   endtask

   task automatic wake_up();
      u_host.wake();
      for (i = 0; i < 50 && rx_enable !== 1'b1; i++) tick(1);
      `CHK("rx_on", 1'b1, rx_enable);
      tick(6);
   endtask

   task automatic quiet_low();
      repeat (20)
      begin
         tick(1);
         `CHK("q_standby", word_t'(0), q);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      finish_test();
   end

   initial
   begin
      reset = 1'b1;
      hold_output = 1'b0;
      mon_on = 1'b0;
      prev_q = '0;
      error_cnt = 0;
      cmp_count = 0;
      w = word_t'($urandom(32'h6377c8c5));
      tick(4);
      reset = 1'b0;
      tick(1);
      `CHK("q_reset", word_t'(0), q);
      `CHK("rx_reset", 1'b0, rx_enable);
      quiet_low();
      $display("test standby done");

      wake_up();
      mon_on = 1'b1;
      push_send(26'h3ffffff);
      push_send(26'h2aaaaaa);
      push_send(26'h1555555);
      for (n = 0; n < 6; n++) push_send(word_t'($urandom));
      drain();
      u_host.set_data(word_t'($urandom));
      tick(20);
      $display("test capture done");

      hold_output = 1'b1;
      for (n = 0; n < 24 && capture_ready === 1'b1; n++) push_send(word_t'($urandom));
      `CHK("full", 1'b0, capture_ready);
      u_host.send(word_t'($urandom));
      tick(10);
      hold_output = 1'b0;
      drain();
      $display("test hold done");

      hold_output = 1'b1;
      for (n = 0; n < 3; n++) u_host.send(word_t'($urandom));
      mon_on = 1'b0;
      u_host.sleep();
      tick(10);
      `CHK("q_sleep", word_t'(0), q);
      `CHK("rx_sleep", 1'b0, rx_enable);
      hold_output = 1'b0;
      quiet_low();
      wake_up();
      mon_on = 1'b1;
      push_send(word_t'($urandom));
      push_send(word_t'($urandom));
      drain();
      $display("test resume done");
      finish_test();
   end
endmodule

`default_nettype wire
